// *** src/tsmc_defs.vh ***
// Constants of the touch-screen manual control block.
// Assumes an APB master, an external converter and an auto sequencer.
// Overview of operation
// - Bits 5:4 route X+ (00), Y+ (01), X- (10) or Y- (11) to the converter.
// - X-pin measurements land in the X result, Y-pin ones in the Y result.
// - Writing one to bit 6 while idle starts a touch measurement or sequence.
// - Without auto mode a trigger runs one measurement set by bits 3:0, 5:4.
// - With auto mode a trigger runs one chosen sequence with switches 3:0 held open; bits 5:4 still drive the route.
// - Bit 6 reads one while running and clears itself when done.
// - Bit 7 picks touch reference pin/ground (0) or the driven plates (1).
// - Reading the X high byte freezes X and Y for the following reads.
`ifndef TSMC_DEFS_VH
`define TSMC_DEFS_VH

// Register indices; byte address is four times the index
`define TSMC_IDX_CTRL 10'h06a
`define TSMC_IDX_XHI 10'h06b
`define TSMC_IDX_YHI 10'h06c
`define TSMC_IDX_LSB 10'h06d
`define TSMC_IDX_ZHI 10'h06e
`define TSMC_ADDR_LSB 2

// Control field positions
`define TSMC_SW_HI 3
`define TSMC_ROUTE_HI 5
`define TSMC_ROUTE_LO 4
`define TSMC_ROUTE_Y 4
`define TSMC_TRIG 6
`define TSMC_REF 7
`define TSMC_ROUTE_RST 2'h0

// Result byte split: high byte 9:2, low pair 1:0
`define TSMC_RES_HI 9
`define TSMC_RES_MID 2
`define TSMC_RES_LSB_HI 1

`define TSMC_CTRL_RST 8'h00
`define TSMC_RES_RST 10'h000
`define TSMC_SW_OFF 4'h0

// Result axis codes from the sequencer
`define TSMC_AXIS_X 2'h0
`define TSMC_AXIS_Y 2'h1
`define TSMC_AXIS_Z 2'h2

`endif

// *** src/tsmc_top.v ***
// Touch-screen manual control register, APB slave and trigger sequencer.
// Assumes a converter with start/done handshake and an auto sequencer
// that reports results through the valid/axis/data inputs.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "tsmc_defs.vh"

module tsmc_top (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output wire [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire AUTO_SEQ_EN_IN,
  input wire PEN_DOWN_IN,
  input wire CONV_DONE_IN,
  input wire [9:0] CONV_DATA_IN,
  input wire SEQ_DONE_IN,
  input wire SEQ_RES_VALID_IN,
  input wire [1:0] SEQ_RES_AXIS_IN,
  input wire [9:0] SEQ_RES_DATA_IN,
  output wire [3:0] PLATE_SW_OUT,
  output wire [1:0] PIN_ROUTE_OUT,
  output wire REF_SELECT_OUT,
  output wire CONV_START_OUT,
  output wire SEQ_START_OUT,
  output wire BUSY_OUT
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_MSTART = 4'b0010;
  localparam [3:0] ST_MWAIT = 4'b0100;
  localparam [3:0] ST_SWAIT = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] ctrl_q;
  reg [9:0] x_res_q;
  reg [9:0] y_res_q;
  reg [9:0] z_res_q;
  reg [9:0] x_snap_q;
  reg [9:0] y_snap_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [3:0] sw_q;
  reg [1:0] route_q;
  reg ref_q;
  reg conv_start_q;
  reg seq_start_q;
  reg busy_q;

  //////////////////////////////////////////////////////////////////////////
  // APB decode

  wire [9:0] word_idx;
  wire access;
  wire done;
  wire wr_done;
  wire hit_ctrl;
  wire hit_xhi;
  wire hit_yhi;
  wire hit_lsb;
  wire hit_zhi;
  wire mapped;
  wire trig_req;
  wire idle;
  reg [7:0] rd_val;
  reg pready_d;
  reg pslverr_d;
  reg [31:0] prdata_d;

  assign word_idx = PADDR_IN[11:`TSMC_ADDR_LSB];
  assign access = PSEL_IN & PENABLE_IN;
  // One wait state: pready rises in the second access cycle
  assign done = access & pready_q;
  assign wr_done = done & PWRITE_IN;
  assign hit_ctrl = (word_idx == `TSMC_IDX_CTRL);
  assign hit_xhi = (word_idx == `TSMC_IDX_XHI);
  assign hit_yhi = (word_idx == `TSMC_IDX_YHI);
  assign hit_lsb = (word_idx == `TSMC_IDX_LSB);
  assign hit_zhi = (word_idx == `TSMC_IDX_ZHI);
  assign mapped = hit_ctrl | hit_xhi | hit_yhi | hit_lsb | hit_zhi;
  assign idle = state_q[0];
  // Trigger only counts from idle, so a busy run cannot be restarted
  assign trig_req = wr_done & hit_ctrl & PWDATA_IN[`TSMC_TRIG] & idle;

  always @* begin
    rd_val = 8'h00;
    if (hit_ctrl) begin
      rd_val = {ctrl_q[`TSMC_REF], busy_q, ctrl_q[`TSMC_ROUTE_HI:0]};
    end else if (hit_xhi) begin
      // Live value: this read is the one that freezes the pair
      rd_val = x_res_q[`TSMC_RES_HI:`TSMC_RES_MID];
    end else if (hit_yhi) begin
      rd_val = y_snap_q[`TSMC_RES_HI:`TSMC_RES_MID];
    end else if (hit_lsb) begin
      // Live pen state beside the frozen pair and the last Z
      rd_val = {1'b0, PEN_DOWN_IN, z_res_q[`TSMC_RES_LSB_HI:0],
                y_snap_q[`TSMC_RES_LSB_HI:0],
                x_snap_q[`TSMC_RES_LSB_HI:0]};
    end else if (hit_zhi) begin
      rd_val = z_res_q[`TSMC_RES_HI:`TSMC_RES_MID];
    end
  end

  // Response is formed in the first access cycle and shown in the next;
  // the wait state keeps the read mux off the pready path
  always @* begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (access & ~pready_q) begin
      pready_d = 1'b1;
      pslverr_d = ~mapped;
      prdata_d = {24'h00_0000, (PWRITE_IN ? 8'h00 : rd_val)};
    end
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register

  reg [7:0] ctrl_d;

  // Bit 6 is kept only for width; the trigger state lives in the sequencer,
  // so a trigger written while busy cannot restart a run in progress
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_done & hit_ctrl) begin
      ctrl_d = PWDATA_IN[`TSMC_REF:0];
    end
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= `TSMC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger sequencer

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (trig_req) begin
          state_d = AUTO_SEQ_EN_IN ? ST_SWAIT : ST_MSTART;
        end
      end
      ST_MSTART: begin
        state_d = ST_MWAIT;
      end
      ST_MWAIT: begin
        if (CONV_DONE_IN) begin
          state_d = ST_IDLE;
        end
      end
      ST_SWAIT: begin
        if (SEQ_DONE_IN) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      conv_start_q <= 1'b0;
      seq_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= ~state_d[0];
      conv_start_q <= state_d[1];
      // Auto run: one sequence start, sequencer owns the switches
      seq_start_q <= idle & trig_req & AUTO_SEQ_EN_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Plate switches, routing and reference

  wire seq_run;
  wire [3:0] sw_d;

  assign seq_run = state_q[3] | state_d[3];

  // One gate per plate: a running sequence owns the plates, so every
  // manual switch is held open until it ends
  genvar sw_i;
  generate
    for (sw_i = 0; sw_i <= `TSMC_SW_HI; sw_i = sw_i + 1) begin : g_plate
      assign sw_d[sw_i] = ctrl_q[sw_i] & ~seq_run;
    end
  endgenerate

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sw_q <= `TSMC_SW_OFF;
      route_q <= `TSMC_ROUTE_RST;
      ref_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      route_q <= ctrl_q[`TSMC_ROUTE_HI:`TSMC_ROUTE_LO];
      ref_q <= ctrl_q[`TSMC_REF];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Results and coherent snapshot

  wire man_store;
  wire man_is_y;
  wire store_x;
  wire store_y;
  wire store_z;
  wire [9:0] store_data;
  wire snap_take;
  reg [9:0] x_res_d;
  reg [9:0] y_res_d;
  reg [9:0] z_res_d;
  reg [9:0] x_snap_d;
  reg [9:0] y_snap_d;

  assign man_store = state_q[2] & CONV_DONE_IN;
  // Odd route codes are Y pins, even codes X pins
  assign man_is_y = route_q[0];
  assign store_x = (man_store & ~man_is_y) |
    (SEQ_RES_VALID_IN & (SEQ_RES_AXIS_IN == `TSMC_AXIS_X));
  assign store_y = (man_store & man_is_y) |
    (SEQ_RES_VALID_IN & (SEQ_RES_AXIS_IN == `TSMC_AXIS_Y));
  assign store_z = SEQ_RES_VALID_IN & (SEQ_RES_AXIS_IN == `TSMC_AXIS_Z);

  assign store_data = man_store ? CONV_DATA_IN : SEQ_RES_DATA_IN;

  always @* begin
    x_res_d = x_res_q;
    y_res_d = y_res_q;
    z_res_d = z_res_q;
    if (store_x) begin
      x_res_d = store_data;
    end
    if (store_y) begin
      y_res_d = store_data;
    end
    if (store_z) begin
      z_res_d = SEQ_RES_DATA_IN;
    end
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      x_res_q <= `TSMC_RES_RST;
      y_res_q <= `TSMC_RES_RST;
      z_res_q <= `TSMC_RES_RST;
    end else begin
      x_res_q <= x_res_d;
      y_res_q <= y_res_d;
      z_res_q <= z_res_d;
    end
  end

  // Snapshot taken when the X high read is sampled into prdata, so the
  // byte returned and the frozen pair come from the same instant
  assign snap_take = access & ~pready_q & ~PWRITE_IN & hit_xhi;

  always @* begin
    x_snap_d = x_snap_q;
    y_snap_d = y_snap_q;
    if (snap_take) begin
      x_snap_d = x_res_q;
      y_snap_d = y_res_q;
    end
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      x_snap_q <= `TSMC_RES_RST;
      y_snap_q <= `TSMC_RES_RST;
    end else begin
      x_snap_q <= x_snap_d;
      y_snap_q <= y_snap_d;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign PLATE_SW_OUT = sw_q;
  assign PIN_ROUTE_OUT = route_q;
  assign REF_SELECT_OUT = ref_q;
  assign CONV_START_OUT = conv_start_q;
  assign SEQ_START_OUT = seq_start_q;
  assign BUSY_OUT = busy_q;

endmodule // tsmc_top

// *** tb/tsmc_top_assertions.sv ***
// Checker for the touch control outputs, watching top ports only.
// Assumes tsmc_top with one APB wait state; bound at the file foot.
`timescale 1ns/1ps
module tsmc_chk (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire [31:0] PRDATA_OUT,
  input wire PREADY_OUT,
  input wire AUTO_SEQ_EN_IN,
  input wire CONV_DONE_IN,
  input wire SEQ_DONE_IN,
  input wire [3:0] PLATE_SW_OUT,
  input wire [1:0] PIN_ROUTE_OUT,
  input wire REF_SELECT_OUT,
  input wire CONV_START_OUT,
  input wire SEQ_START_OUT,
  input wire BUSY_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire ctl = PSEL_IN && PENABLE_IN && PREADY_OUT && PADDR_IN == 12'h01a8;
  wire wr = ctl && PWRITE_IN;
  wire go = wr && PWDATA_IN[6] && !BUSY_OUT;
  reg man_q;
  // Remembers which kind of run is open, so the right done pulse counts
  always @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) man_q <= 1'h0;
    else if (CONV_START_OUT | SEQ_START_OUT) man_q <= CONV_START_OUT;
  route_follow_a:
    assert property (wr |-> ##2 PIN_ROUTE_OUT == $past(PWDATA_IN[5:4], 2))
    else $error("route output wrong");
  ref_follow_a:
    assert property (wr |-> ##2 REF_SELECT_OUT == $past(PWDATA_IN[7], 2))
    else $error("reference output wrong");
  switch_follow_a:
    assert property (wr && !AUTO_SEQ_EN_IN && !BUSY_OUT |-> ##2
      PLATE_SW_OUT == $past(PWDATA_IN[3:0], 2)) else $error("switches wrong");
  manual_start_a:
    assert property (go && !AUTO_SEQ_EN_IN |=> CONV_START_OUT && BUSY_OUT
      && !SEQ_START_OUT ##1 !CONV_START_OUT) else $error("no manual start");
  auto_start_a:
    assert property (go && AUTO_SEQ_EN_IN |=> SEQ_START_OUT && BUSY_OUT
      && !CONV_START_OUT) else $error("no sequence start");
  no_restart_a:
    assert property (BUSY_OUT |=> !CONV_START_OUT && !SEQ_START_OUT)
    else $error("restart while busy");
  done_clear_a:
    assert property (BUSY_OUT && (man_q ? CONV_DONE_IN : SEQ_DONE_IN)
      |=> !BUSY_OUT) else $error("trigger bit not cleared");
  busy_read_a:
    assert property (ctl && !PWRITE_IN |-> PRDATA_OUT[6] == $past(BUSY_OUT))
    else $error("trigger readback wrong");
  auto_switch_open_a:
    assert property (BUSY_OUT && !man_q && !CONV_START_OUT |->
      PLATE_SW_OUT == 4'h0) else $error("switches closed in sequence");
  cover property (go && AUTO_SEQ_EN_IN);
  cover property (go && !AUTO_SEQ_EN_IN);
  cover property (wr && PWDATA_IN[6] && BUSY_OUT);
endmodule // tsmc_chk
bind tsmc_top tsmc_chk u_chk (.*);

// *** tb/tsmc_conv_model.sv ***
// Converter and sequencer model at the far side of the block.
// Assumes one-cycle start pulses; answers dly_in+3 cycles later.
`timescale 1ns/1ps
module tsmc_conv_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire conv_start_in,
  input wire seq_start_in,
  input wire [3:0] dly_in,
  input wire [9:0] val_in,
  output wire conv_done_out,
  output wire seq_done_out,
  output wire seq_valid_out,
  output wire [1:0] seq_axis_out,
  output wire [9:0] data_out
);
  reg m_q;
  reg [4:0] n_q;
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) begin
      n_q <= 5'h0;
      m_q <= 1'h0;
    end else if (conv_start_in | seq_start_in) begin
      n_q <= {1'h0, dly_in} + 5'h3;
      m_q <= conv_start_in;
    end else if (n_q != 5'h0) begin
      n_q <= n_q - 5'h1;
    end
  assign conv_done_out = m_q && n_q == 5'h1;
  assign seq_valid_out = !m_q && (n_q == 5'h3 || n_q == 5'h2);
  assign seq_axis_out = {1'h0, n_q == 5'h2};
  assign seq_done_out = !m_q && n_q == 5'h1;
  // Idle data shows the inverse, so stale values never look valid
  assign data_out = (n_q == 5'h1 || n_q == 5'h3) ? val_in : ~val_in;
endmodule // tsmc_conv_model

// *** tb/touch_screen_manual_control_bench.sv ***
// Bench for the touch manual control block and its converter model.
// Assumes tsmc_top, tsmc_conv_model and the checker bind are compiled.
`timescale 1ns/1ps
module touch_screen_manual_control_bench;
  reg CLK_IN = 0, RST_N_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  reg AUTO_SEQ_EN_IN = 0, PEN_DOWN_IN = 0;
  reg [11:0] PADDR_IN = 0;
  reg [31:0] PWDATA_IN = 0;
  wire [31:0] PRDATA_OUT;
  wire PREADY_OUT, PSLVERR_OUT, CONV_DONE_IN, SEQ_DONE_IN, SEQ_RES_VALID_IN;
  wire CONV_START_OUT, SEQ_START_OUT, BUSY_OUT, REF_SELECT_OUT;
  wire [1:0] SEQ_RES_AXIS_IN, PIN_ROUTE_OUT;
  wire [9:0] CONV_DATA_IN, SEQ_RES_DATA_IN;
  wire [3:0] PLATE_SW_OUT;
  reg [3:0] dly = 0;
  reg [9:0] val = 0, xr = 0, yr = 0;
  reg [7:0] d;
  reg [8:0] q[$];
  integer bad_count = 0, checks_done = 0, i, j;
  always #2.5 CLK_IN = ~CLK_IN;
  tsmc_top dut (.*);
  tsmc_conv_model far (.clk_in(CLK_IN), .rst_n_in(RST_N_IN),
    .conv_start_in(CONV_START_OUT), .seq_start_in(SEQ_START_OUT),
    .dly_in(dly), .val_in(val), .conv_done_out(CONV_DONE_IN),
    .seq_done_out(SEQ_DONE_IN), .seq_valid_out(SEQ_RES_VALID_IN),
    .seq_axis_out(SEQ_RES_AXIS_IN), .data_out(CONV_DATA_IN));
  assign SEQ_RES_DATA_IN = CONV_DATA_IN;
  task chk(input [8:0] got, input [8:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; x is the expected {error, byte} of its answer
  task acc(input w, input [11:0] a, input [7:0] v, input [8:0] x);
    begin
      @(posedge CLK_IN);
      PSEL_IN <= 1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= {24'h0, v};
      q.push_back(x);
      @(posedge CLK_IN);
      PENABLE_IN <= 1;
      @(posedge CLK_IN);
      while (PREADY_OUT !== 1) @(posedge CLK_IN);
      PSEL_IN <= 0;
      PENABLE_IN <= 0;
    end
  endtask
  task wt;
    begin
      @(posedge CLK_IN);
      repeat (60) if (BUSY_OUT !== 0) @(posedge CLK_IN);
      chk({8'h00, BUSY_OUT}, 9'h000);
    end
  endtask
  task rd_xy;
    begin
      acc(0, 12'h01ac, 0, {1'h0, xr[9:2]});
      acc(0, 12'h01b0, 0, {1'h0, yr[9:2]});
    end
  endtask
  always @(posedge CLK_IN)
    if (PREADY_OUT === 1) chk({PSLVERR_OUT, PRDATA_OUT[7:0]}, q.pop_front());
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    i = $urandom(71596);
    repeat (6) @(posedge CLK_IN);
    RST_N_IN <= 1;
    acc(0, 12'h01a8, 0, 0);
    acc(0, 12'h0000, 0, 9'h100);
    acc(1, 12'h01ac, 8'hff, 0);
    rd_xy;
    $display("reset test done");
    for (j = 0; j < 4; j = j + 1) begin
      d = $urandom;
      d[6] = 1;
      d[5:4] = j[1:0];
      val <= $urandom;
      dly <= 5 + $urandom % 4;
      PEN_DOWN_IN <= $urandom;
      acc(1, 12'h01a8, d, 0);
      acc(0, 12'h01a8, 0, {1'h0, d});
      acc(1, 12'h01a8, d, 0);
      wt;
      if (j[0]) yr = val;
      else xr = val;
      acc(0, 12'h01a8, 0, {2'h0, d[5:0]} | {d[7], 7'h0});
      rd_xy;
      acc(0, 12'h01b4, 0, {2'h0, PEN_DOWN_IN, 2'h0, yr[1:0], xr[1:0]});
    end
    acc(0, 12'h01ac, 0, {1'h0, xr[9:2]});
    val <= $urandom;
    acc(1, 12'h01a8, 8'h50, 0);
    wt;
    acc(0, 12'h01b0, 0, {1'h0, yr[9:2]});
    yr = val;
    $display("manual test done");
    AUTO_SEQ_EN_IN <= 1;
    dly <= 0;
    val <= $urandom;
    acc(1, 12'h01a8, 8'h4f, 0);
    wt;
    xr = val;
    yr = ~val;
    rd_xy;
    $display("sequence test done");
    repeat (3) @(posedge CLK_IN);
    final_report;
  end
endmodule // touch_screen_manual_control_bench
